// ---- core/ssc_defs.vh ----
// constants shared by the synchronous serial channel design
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// register addresses on the cpu memory bus
`define SSC_ADDR_BUF0 16'hffe2
`define SSC_ADDR_MOD0 16'hffe3
`define SSC_ADDR_BUF1 16'hffe4
`define SSC_ADDR_MOD1 16'hffe5
`define SSC_ADDR_SRC 16'hffec

// mode register field positions
`define SSC_MOD_EN 0
`define SSC_MOD_MODE_LO 1
`define SSC_MOD_MODE_HI 2
`define SSC_MOD_EDGE 3
`define SSC_MOD_RATE 4
`define SSC_MOD_SRC 5
`define SSC_MOD_MON 7

// transfer mode encodings
`define SSC_MODE_TX 2'h0
`define SSC_MODE_RX 2'h1
`define SSC_MODE_TXRX 2'h2

// reset values
`define SSC_MOD_RESET 8'h80
`define SSC_BUF_RESET 8'h00
`define SSC_SRC_RESET 2'h0

// timing: fc is the reference the shift rates are quoted against
`define SSC_CLK_HZ 250000000
`define SSC_FC_HZ 10000000
`define SSC_DIV_FAST 8
`define SSC_DIV_SLOW 128
`define SSC_HALF_FAST ((`SSC_CLK_HZ / `SSC_FC_HZ) * `SSC_DIV_FAST / 2)
`define SSC_HALF_SLOW ((`SSC_CLK_HZ / `SSC_FC_HZ) * `SSC_DIV_SLOW / 2)

// receive fifo
`define SSC_FIFO_WIDTH 8
`define SSC_FIFO_DEPTH 8

`endif

// ---- core/ssc_fifo.v ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module ssc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clock,
   input wire rstn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clock) begin
      if (!rstn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // ssc_fifo

// ---- core/ssc_serial.v ----
// two-channel synchronous serial block with cpu register port
`timescale 1ns/10ps
`include "ssc_defs.vh"

module ssc_serial (
   input wire clock,
   input wire rstn,
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   input wire cpu_wr,
   input wire cpu_rd,
   output reg [7:0] cpu_rdata,
   input wire shift_clock_pin_ch0_in,
   output wire shift_clock_pin_ch0_out,
   output wire shift_clock_pin_ch0_oe,
   output wire transmit_pin_ch0,
   input wire receive_pin_ch0,
   input wire shift_clock_pin_ch1_in,
   output wire shift_clock_pin_ch1_out,
   output wire shift_clock_pin_ch1_oe,
   output wire transmit_pin_ch1,
   input wire receive_pin_ch1,
   output wire serial_buffer_irq_ch0,
   output wire serial_buffer_irq_ch1
);
   wire [1:0] wr_buf;
   wire [1:0] wr_mod;
   wire [1:0] rd_buf;
   wire rd_src;
   wire [1:0] sclk_in;
   wire [1:0] rxd_in;
   wire [1:0] sclk_out;
   wire [1:0] sclk_oe;
   wire [1:0] txd_out;
   wire [1:0] irq_out;
   wire [1:0] flag_set;
   wire [15:0] buf_view;
   wire [15:0] mod_view;
   reg [1:0] interrupt_source_flags;

   // cpu address decode
   assign wr_buf[0] = cpu_wr & (cpu_addr == `SSC_ADDR_BUF0);
   assign wr_buf[1] = cpu_wr & (cpu_addr == `SSC_ADDR_BUF1);
   assign wr_mod[0] = cpu_wr & (cpu_addr == `SSC_ADDR_MOD0);
   assign wr_mod[1] = cpu_wr & (cpu_addr == `SSC_ADDR_MOD1);
   assign rd_buf[0] = cpu_rd & (cpu_addr == `SSC_ADDR_BUF0);
   assign rd_buf[1] = cpu_rd & (cpu_addr == `SSC_ADDR_BUF1);
   assign rd_src = cpu_rd & (cpu_addr == `SSC_ADDR_SRC);

   assign sclk_in = {shift_clock_pin_ch1_in, shift_clock_pin_ch0_in};
   assign rxd_in = {receive_pin_ch1, receive_pin_ch0};
   assign shift_clock_pin_ch0_out = sclk_out[0];
   assign shift_clock_pin_ch1_out = sclk_out[1];
   assign shift_clock_pin_ch0_oe = sclk_oe[0];
   assign shift_clock_pin_ch1_oe = sclk_oe[1];
   assign transmit_pin_ch0 = txd_out[0];
   assign transmit_pin_ch1 = txd_out[1];
   assign serial_buffer_irq_ch0 = irq_out[0];
   assign serial_buffer_irq_ch1 = irq_out[1];

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : chan
         reg sclk_s1;
         reg sclk_s2;
         reg sclk_s3;
         reg rxd_s1;
         reg rxd_s2;
         reg en;
         reg [1:0] mode;
         reg edge_sel;
         reg rate_sel;
         reg ext_sel;
         reg monitor;
         reg [7:0] buffer;
         reg tx_ready;
         reg rx_full;
         reg irq;
         reg busy;
         reg [2:0] bitcnt;
         reg [7:0] sh_tx;
         reg [7:0] sh_rx;
         reg txd;
         reg sclk_gen;
         reg oe;
         reg int_fall;
         reg int_rise;
         reg [11:0] div_cnt;
         reg push_valid;
         reg [7:0] push_data;
         wire push_ready;
         wire pop_valid;
         wire [7:0] pop_data;
         wire pop_ready;
         wire fall;
         wire rise;
         wire tx_mode;
         wire rx_mode;
         wire drive_edge;
         wire sample_edge;
         wire count_edge;
         wire start_ok;
         wire gen_run;
         wire [31:0] half;
         wire [7:0] rx_next;

         // pin inputs cross into the core clock through two flops
         always @(posedge clock) begin
            if (!rstn) begin
               sclk_s1 <= 1'b1;
               sclk_s2 <= 1'b1;
               sclk_s3 <= 1'b1;
               rxd_s1 <= 1'b1;
               rxd_s2 <= 1'b1;
            end else begin
               sclk_s1 <= sclk_in[ch];
               sclk_s2 <= sclk_s1;
               sclk_s3 <= sclk_s2;
               rxd_s1 <= rxd_in[ch];
               rxd_s2 <= rxd_s1;
            end
         end

         assign tx_mode = (mode != `SSC_MODE_RX);
         assign rx_mode = (mode != `SSC_MODE_TX);
         // external edges come from the synced pin, internal from divider
         assign fall = ext_sel ? (sclk_s3 & ~sclk_s2) : int_fall;
         assign rise = ext_sel ? (~sclk_s3 & sclk_s2) : int_rise;
         // falling edge is the leading edge
         assign drive_edge = tx_mode & fall;
         assign sample_edge = (mode == `SSC_MODE_RX) ?
            (edge_sel ? fall : rise) : rise;
         assign count_edge = (mode == `SSC_MODE_TX) ? rise : sample_edge;
         assign rx_next = {rxd_s2, sh_rx[7:1]};
         // send waits for data, receive waits for room to store
         assign start_ok = (mode == `SSC_MODE_TX) ? tx_ready :
            (mode == `SSC_MODE_RX) ? push_ready :
            (tx_ready & push_ready);
         assign gen_run = busy | (en & start_ok & ~push_valid);
         assign half = rate_sel ? `SSC_HALF_SLOW : `SSC_HALF_FAST;
         assign pop_ready = rx_mode & ~rx_full;

         // internal shift clock: finishes its low half before stopping
         always @(posedge clock) begin
            if (!rstn) begin
               sclk_gen <= 1'b1;
               div_cnt <= 12'h000;
               int_fall <= 1'b0;
               int_rise <= 1'b0;
               oe <= 1'b0;
            end else begin
               oe <= ~ext_sel;
               int_fall <= 1'b0;
               int_rise <= 1'b0;
               if (!ext_sel && (gen_run || !sclk_gen)) begin
                  if (div_cnt == half[11:0] - 12'h001) begin
                     div_cnt <= 12'h000;
                     sclk_gen <= ~sclk_gen;
                     int_fall <= sclk_gen;
                     int_rise <= ~sclk_gen;
                  end else begin
                     div_cnt <= div_cnt + 12'h001;
                  end
               end else begin
                  div_cnt <= 12'h000;
                  sclk_gen <= 1'b1;
               end
            end
         end

         // channel control, shifters and shared buffer
         always @(posedge clock) begin
            if (!rstn) begin
               en <= 1'b0;
               mode <= `SSC_MODE_TX;
               edge_sel <= 1'b0;
               rate_sel <= 1'b0;
               ext_sel <= 1'b0;
               monitor <= 1'b1;
               buffer <= `SSC_BUF_RESET;
               tx_ready <= 1'b0;
               rx_full <= 1'b0;
               irq <= 1'b0;
               busy <= 1'b0;
               bitcnt <= 3'h0;
               sh_tx <= 8'hff;
               sh_rx <= 8'h00;
               txd <= 1'b1;
               push_valid <= 1'b0;
               push_data <= 8'h00;
            end else begin
               push_valid <= 1'b0;
               // cpu side: clears first so hardware sets below win
               if (wr_mod[ch]) begin
                  en <= cpu_wdata[`SSC_MOD_EN];
                  mode <= cpu_wdata[`SSC_MOD_MODE_HI:`SSC_MOD_MODE_LO];
                  edge_sel <= cpu_wdata[`SSC_MOD_EDGE];
                  rate_sel <= cpu_wdata[`SSC_MOD_RATE];
                  ext_sel <= cpu_wdata[`SSC_MOD_SRC];
                  if (cpu_wdata[`SSC_MOD_EN]) begin
                     monitor <= 1'b0;
                  end
                  if (cpu_wdata[`SSC_MOD_MODE_HI:`SSC_MOD_MODE_LO] != mode)
                  begin
                     // buffer contents are not kept across a mode change
                     buffer <= `SSC_BUF_RESET;
                     tx_ready <= 1'b0;
                     rx_full <= 1'b0;
                     irq <= 1'b0;
                  end
               end
               if (wr_buf[ch] && tx_mode) begin
                  buffer <= cpu_wdata;
                  tx_ready <= 1'b1;
                  irq <= 1'b0;
               end
               if (rd_buf[ch] && rx_mode) begin
                  rx_full <= 1'b0;
                  irq <= 1'b0;
               end
               // next received byte enters buffer once it is free
               if (pop_valid && pop_ready) begin
                  buffer <= pop_data;
                  rx_full <= 1'b1;
                  irq <= 1'b1;
               end
               // leading edge: start a byte or shift out the next bit
               if (drive_edge) begin
                  if (!busy && en) begin
                     // unloaded external byte goes out as a dummy
                     sh_tx <= buffer;
                     txd <= buffer[0];
                     tx_ready <= wr_buf[ch]; // same-cycle write wins
                     busy <= 1'b1;
                     bitcnt <= 3'h0;
                     if (mode == `SSC_MODE_TX) begin
                        irq <= 1'b1;
                     end
                  end else if (busy) begin
                     sh_tx <= {1'b1, sh_tx[7:1]};
                     txd <= sh_tx[1];
                  end
               end
               // receive shifting, lsb arrives first
               if (sample_edge && rx_mode && (busy || en)) begin
                  sh_rx <= rx_next;
                  if (mode == `SSC_MODE_RX && !busy) begin
                     busy <= 1'b1;
                     // first bit is already in, so seven more to go
                     bitcnt <= 3'h1;
                  end
               end
               // frame end: byte is always completed even when disabled
               if (count_edge && busy) begin
                  if (bitcnt == 3'h7) begin
                     busy <= 1'b0;
                     bitcnt <= 3'h0;
                     if (mode == `SSC_MODE_TX) begin
                        txd <= 1'b1;
                     end
                     if (rx_mode) begin
                        // a full store drops the byte
                        push_valid <= push_ready;
                        push_data <= rx_next;
                     end
                     if (!en) begin
                        monitor <= 1'b1;
                     end
                  end else begin
                     bitcnt <= bitcnt + 3'h1;
                  end
               end
            end
         end

         // received byte queue between the shifter and the buffer register
         ssc_fifo #(
            .WIDTH(`SSC_FIFO_WIDTH),
            .DEPTH(`SSC_FIFO_DEPTH),
            .AW(3)
         ) rx_queue (
            .clock(clock),
            .rstn(rstn),
            .in_valid(push_valid),
            .in_ready(push_ready),
            .in_data(push_data),
            .out_valid(pop_valid),
            .out_ready(pop_ready),
            .out_data(pop_data)
         );

         // source flag pulses when this channel raises its request
         reg irq_d;
         always @(posedge clock) begin
            if (!rstn) begin
               irq_d <= 1'b0;
            end else begin
               irq_d <= irq;
            end
         end
         assign flag_set[ch] = irq & ~irq_d;

         assign sclk_out[ch] = sclk_gen;
         assign sclk_oe[ch] = oe;
         assign txd_out[ch] = txd;
         assign irq_out[ch] = irq_d;
         assign buf_view[ch*8 +: 8] = buffer;
         assign mod_view[ch*8 +: 8] = {monitor, 1'b0, ext_sel, rate_sel,
            edge_sel, mode, en};
      end
   endgenerate

   // source register: a new event wins over a clearing read
   always @(posedge clock) begin
      if (!rstn) begin
         interrupt_source_flags <= `SSC_SRC_RESET;
      end else begin
         interrupt_source_flags <= (rd_src ? 2'h0 : interrupt_source_flags)
            | flag_set;
      end
   end

   // registered read data; unmapped addresses read zero
   always @(posedge clock) begin
      if (!rstn) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_rd) begin
         if (cpu_addr == `SSC_ADDR_BUF0) begin
            cpu_rdata <= buf_view[7:0];
         end else if (cpu_addr == `SSC_ADDR_MOD0) begin
            cpu_rdata <= mod_view[7:0];
         end else if (cpu_addr == `SSC_ADDR_BUF1) begin
            cpu_rdata <= buf_view[15:8];
         end else if (cpu_addr == `SSC_ADDR_MOD1) begin
            cpu_rdata <= mod_view[15:8];
         end else if (cpu_addr == `SSC_ADDR_SRC) begin
            cpu_rdata <= {6'h00, interrupt_source_flags};
         end else begin
            cpu_rdata <= 8'h00;
         end
      end
   end
endmodule // ssc_serial

// ---- testbench/ssc_far_end.sv ----
// far-end serial circuit: shifts bytes in and out, makes external clock
`timescale 1ns/10ps
module ssc_far_end (
   input wire logic clk_pin,
   input wire logic txd,
   input wire logic go,
   input wire logic [7:0] rx_byte,
   output logic ext_clk,
   output logic rxd,
   output logic [7:0] got,
   output logic [7:0] cnt
);
   logic [7:0] sr, cur;
   int n = 0;
   // unknown-to-high steps at start-up are not clock edges
   logic armed = 1'b0;
   initial begin
      ext_clk = 1'b1;
      rxd = 1'b1;
      cnt = 8'h00;
      got = 8'h00;
   end
   // clock runs only within a frame, idles high between frames
   always @(posedge go)
      repeat (8) begin
         #62.5 ext_clk = 1'b0;
         #62.5 ext_clk = 1'b1;
      end
   // first bit stands before the first clock edge
   always @(rx_byte)
      if (n == 0)
         rxd = rx_byte[0];
   always @(posedge clk_pin) begin
      if (armed) begin
         if (n == 0)
            cur = rx_byte;
         sr = {txd, sr[7:1]};
         n = n + 1;
         if (n == 8) begin
            got = sr;
            cnt = cnt + 8'h01;
            n = 0;
            rxd <= #40 rx_byte[0];
         end
      end
   end
   // bit moves on only after its sampling edge has passed
   always @(negedge clk_pin) begin
      if (clk_pin === 1'b0)
         armed = 1'b1;
      if (n > 0)
         rxd = cur[n];
   end
endmodule // ssc_far_end

// ---- testbench/ssc_serial_chk.sv ----
// port assertions for the two-channel serial block
`timescale 1ns/10ps
`include "ssc_defs.vh"
module ssc_serial_chk (
   input wire clock,
   input wire rstn,
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   input wire cpu_wr,
   input wire cpu_rd,
   input wire [7:0] cpu_rdata,
   input wire shift_clock_pin_ch0_out,
   input wire shift_clock_pin_ch0_oe,
   input wire shift_clock_pin_ch1_oe,
   input wire shift_clock_pin_ch1_out,
   input wire serial_buffer_irq_ch0
);
   localparam logic [11:0] HALF = `SSC_HALF_FAST;
   logic [7:0] m0, m1;
   logic [11:0] low0;
   logic [2:0] nfall;
   logic last0;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // mirror of mode writes; frames always end on a multiple of 8 falls
   always @(posedge clock) begin
      if (!rstn) begin
         m0 <= 8'h00;
         m1 <= 8'h00;
         low0 <= 12'h000;
         nfall <= 3'h0;
         last0 <= 1'b1;
      end else begin
         if (cpu_wr && cpu_addr == `SSC_ADDR_MOD0)
            m0 <= cpu_wdata;
         if (cpu_wr && cpu_addr == `SSC_ADDR_MOD1)
            m1 <= cpu_wdata;
         low0 <= shift_clock_pin_ch0_out ? 12'h000 : low0 + 12'h001;
         last0 <= shift_clock_pin_ch0_out;
         if (last0 && !shift_clock_pin_ch0_out)
            nfall <= nfall + 3'h1;
      end
   end
   a_fall_needs_oe: assert property (
      $fell(shift_clock_pin_ch0_out) |-> shift_clock_pin_ch0_oe)
      else $error("shift clock fell while not driven");
   a_ext_undriven: assert property (
      m1[5] |=> !shift_clock_pin_ch1_oe)
      else $error("external clock pin still driven");
   a_fast_half: assert property (
      $rose(shift_clock_pin_ch0_out) && !m0[4] |-> low0 == HALF)
      else $error("fast shift clock low phase wrong length");
   a_idle_high: assert property (
      !shift_clock_pin_ch1_oe |-> shift_clock_pin_ch1_out)
      else $error("shift clock not high while idle");
   a_irq_at_start: assert property (
      $fell(shift_clock_pin_ch0_out) && nfall == 3'h0 && m0[2:0] == 3'h1
      |-> ##[0:4] serial_buffer_irq_ch0)
      else $error("no buffer request at byte start");
   a_wr_clears_irq: assert property (
      cpu_wr && cpu_addr == `SSC_ADDR_BUF0 && m0[2:1] == 2'h0
      |-> ##2 !serial_buffer_irq_ch0)
      else $error("buffer write left request pending");
   a_src_upper_zero: assert property (
      cpu_rd && cpu_addr == `SSC_ADDR_SRC |=> cpu_rdata[7:2] == 6'h00)
      else $error("source flags upper bits set");
   a_mode_readback: assert property (
      cpu_rd && cpu_addr == `SSC_ADDR_MOD0
      |=> cpu_rdata[6:0] == {1'b0, m0[5:0]})
      else $error("mode register readback wrong");
endmodule // ssc_serial_chk
bind ssc_serial ssc_serial_chk chk (.clock(clock), .rstn(rstn),
   .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
   .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
   .shift_clock_pin_ch0_out(shift_clock_pin_ch0_out),
   .shift_clock_pin_ch0_oe(shift_clock_pin_ch0_oe),
   .shift_clock_pin_ch1_oe(shift_clock_pin_ch1_oe),
   .shift_clock_pin_ch1_out(shift_clock_pin_ch1_out),
   .serial_buffer_irq_ch0(serial_buffer_irq_ch0));

// ---- testbench/test_ssc_serial.sv ----
// self-checking bench: register traffic and far-end serial exchange
`timescale 1ns/10ps
`include "ssc_defs.vh"
module test_ssc_serial;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd_en = 1'b0;
   logic go1 = 1'b0;
   logic [7:0] rb0 = 8'h00;
   logic [7:0] rb1 = 8'h00;
   logic [7:0] b1, b2, v;
   wire [7:0] rdata, got0, got1, cnt0, cnt1;
   wire c0o, c0e, c1o, c1e, tx0, tx1, irq0, irq1, ek0, ek1, rx0, rx1;
   wire p0 = c0e ? c0o : ek0;
   wire p1 = c1e ? c1o : ek1;
   int n_mismatch = 0;
   int checked = 0;
   int i;
   always #2 clock = ~clock;
   ssc_serial uut (.clock(clock), .rstn(rstn), .cpu_addr(addr),
      .cpu_wdata(wdata), .cpu_wr(wr), .cpu_rd(rd_en), .cpu_rdata(rdata),
      .shift_clock_pin_ch0_in(p0), .shift_clock_pin_ch0_out(c0o),
      .shift_clock_pin_ch0_oe(c0e), .transmit_pin_ch0(tx0),
      .receive_pin_ch0(rx0), .shift_clock_pin_ch1_in(p1),
      .shift_clock_pin_ch1_out(c1o), .shift_clock_pin_ch1_oe(c1e),
      .transmit_pin_ch1(tx1), .receive_pin_ch1(rx1),
      .serial_buffer_irq_ch0(irq0), .serial_buffer_irq_ch1(irq1));
   ssc_far_end far0 (.clk_pin(p0), .txd(tx0), .go(1'b0), .rx_byte(rb0),
      .ext_clk(ek0), .rxd(rx0), .got(got0), .cnt(cnt0));
   ssc_far_end far1 (.clk_pin(p1), .txd(tx1), .go(go1), .rx_byte(rb1),
      .ext_clk(ek1), .rxd(rx1), .got(got1), .cnt(cnt1));
   function logic [7:0] mode_rd(input logic mon, input logic [7:0] w);
      mode_rd = {mon, 1'b0, w[5:0]};
   endfunction
   function logic cond(input int sel, input logic [7:0] k);
      case (sel)
         0: cond = irq0;
         1: cond = irq1;
         2: cond = (cnt0 == k);
         default: cond = (cnt1 == k);
      endcase
   endfunction
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task bus_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clock);
      #1;
      wr = 1'b0;
   endtask
   // reads have side effects, so one strobe per call
   task rd_raw(input logic [15:0] a);
      @(posedge clock);
      #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clock);
      #1;
      rd_en = 1'b0;
      @(posedge clock);
      #1;
      v = rdata;
   endtask
   task rd_chk(input logic [15:0] a, input logic [7:0] exp);
      rd_raw(a);
      check(v, exp);
   endtask
   task wait_for(input int sel, input logic [7:0] k);
      for (i = 0; i < 20000 && cond(sel, k) !== 1'b1; i++)
         @(posedge clock);
      #1;
      if (cond(sel, k) !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] t=%0t wait %h ran out, expected=%h", $time, sel, k);
         finish_test();
      end
   endtask
   task wait_mon(input logic [15:0] a);
      for (i = 0; i < 2000 && v[7] !== 1'b1; i++)
         rd_raw(a);
      if (v[7] !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] t=%0t monitor wait seen=%h expected=%h", $time, v,
            8'h80);
         finish_test();
      end
   endtask
   initial begin
      v = $urandom(32'h5532241e);
      repeat (3) @(posedge clock);
      #1;
      rstn = 1'b1;
      rd_chk(`SSC_ADDR_MOD0, mode_rd(1'b1, 8'h00));
      rd_chk(`SSC_ADDR_MOD1, mode_rd(1'b1, 8'h00));
      rd_chk(`SSC_ADDR_SRC, 8'h00);
      rd_chk(16'hffe6, 8'h00);
      check({4'h0, tx0, tx1, c0o, c1o}, 8'h0f);
      $display("test reset done");
      b1 = 8'h01;
      b2 = 8'($urandom);
      bus_wr(`SSC_ADDR_BUF0, b1);
      bus_wr(`SSC_ADDR_MOD0, 8'h01);
      wait_for(0, 8'h00);
      rd_chk(`SSC_ADDR_SRC, 8'h01);
      rd_chk(`SSC_ADDR_SRC, 8'h00);
      bus_wr(`SSC_ADDR_BUF0, b2);
      @(posedge clock);
      #1;
      check({7'h00, irq0}, 8'h00);
      wait_for(2, 8'h01);
      check(got0, b1);
      wait_for(0, 8'h00);
      bus_wr(`SSC_ADDR_MOD0, 8'h00);
      wait_for(2, 8'h02);
      check(got0, b2);
      v = 8'h00;
      addr = `SSC_ADDR_MOD0;
      wait_mon(`SSC_ADDR_MOD0);
      check(v, mode_rd(1'b1, 8'h00));
      repeat (400) @(posedge clock);
      #1;
      check(cnt0, 8'h02);
      check({7'h00, c0o}, 8'h01);
      $display("test send done");
      bus_wr(`SSC_ADDR_MOD0, 8'h02);
      bus_wr(`SSC_ADDR_BUF0, 8'h5a);
      rd_chk(`SSC_ADDR_BUF0, `SSC_BUF_RESET);
      b1 = 8'h80;
      b2 = 8'($urandom);
      rb0 = b1;
      bus_wr(`SSC_ADDR_MOD0, 8'h03);
      repeat (400) @(posedge clock);
      #1;
      rb0 = b2;
      wait_for(0, 8'h00);
      rd_chk(`SSC_ADDR_SRC, 8'h01);
      rd_chk(`SSC_ADDR_BUF0, b1);
      check({7'h00, irq0}, 8'h00);
      // let the second byte get under way before disabling
      repeat (400) @(posedge clock);
      #1;
      bus_wr(`SSC_ADDR_MOD0, 8'h02);
      v = 8'h00;
      addr = `SSC_ADDR_MOD0;
      wait_mon(`SSC_ADDR_MOD0);
      check(v, mode_rd(1'b1, 8'h02));
      rd_chk(`SSC_ADDR_BUF0, b2);
      rd_chk(`SSC_ADDR_SRC, 8'h01);
      $display("test receive done");
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      bus_wr(`SSC_ADDR_MOD1, 8'h24);
      bus_wr(`SSC_ADDR_BUF1, b1);
      rb1 = b2;
      bus_wr(`SSC_ADDR_MOD1, 8'h25);
      check({7'h00, c1e}, 8'h00);
      go1 = 1'b1;
      wait_for(3, 8'h01);
      check(got1, b1);
      wait_for(1, 8'h00);
      rd_chk(`SSC_ADDR_SRC, 8'h02);
      rd_chk(`SSC_ADDR_BUF1, b2);
      $display("test external done");
      finish_test();
   end
endmodule // test_ssc_serial
